// [verilog/csi_map.svh]
`ifndef CSI_MAP_SVH
`define CSI_MAP_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define CSI_IDX_PULL 16'hff45
`define CSI_IDX_CTL  16'hff70
`define CSI_IDX_FMT  16'hff71
`define CSI_IDX_DLO  16'hff72
`define CSI_IDX_DHI  16'hff73
`define CSI_IDX_MASK 16'hffe2
`define CSI_IDX_FLAG 16'hfff2
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSI_CTL_EN   0
`define CSI_CTL_TRG  1
`define CSI_CTL_SOE  2
`define CSI_FMT_EDGE 2
`define CSI_FMT_MSB  3
`define CSI_IRQ_BIT  0
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CSI_PULL_RST 4'hf
`define CSI_LAST_BIT 3'h7
`endif

// [verilog/csi_pkg.sv]
package csi_pkg;
    // Clock source select, two-bit field
    typedef enum logic [1:0] {
        CSI_SLAVE = 2'b00,
        CSI_TIMER = 2'b01,
        CSI_DIV2  = 2'b10,
        CSI_OSC   = 2'b11
    } csi_mode_type;

    typedef enum logic {
        CSI_IDLE = 1'b0,
        CSI_RUN  = 1'b1
    } csi_phase_type;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [17:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } csi_wb_req_type;

    // Wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } csi_wb_rsp_type;

    // Four shared pins: level, enable and pull-down
    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
        logic [3:0] pd;
    } csi_pins_type;

    typedef struct packed {
        logic [2:0]     sync1;
        logic [2:0]     sync2;
        logic [2:0]     sync3;
        logic [2:0]     filt;
        logic           sclk;
        logic           rx_bit;
        logic [7:0]     sh;
        logic [2:0]     cnt;
        csi_phase_type  phase;
        logic           en;
        logic           soe;
        logic [3:0]     pull;
        csi_mode_type   mode;
        logic           edge_sel;
        logic           msb;
        logic           mask;
        logic           flag;
        logic           irq;
        logic           serial_data_out;
        csi_wb_rsp_type rsp;
        csi_pins_type   pins;
    } csi_state_type;
endpackage

// [verilog/csi_serial.sv]
`timescale 1ns/100ps
`include "csi_map.svh"
// Notes on behaviour
// - Enable bit maps three pins to serial, four in slave
// - Pin four is ready output in slave
// - Data out pin driven only when enabled
// - Pull-downs reset on; clock one slave-only
// - Mode field picks clock source, resets slave
// - Timer mode halves timer underflow pulses
// - Phase bit picks input sampling edge
// - Output data changes on fixed edge
// - Order bit: msb or lsb first
// - Writing one triggers; zero does nothing
// - Trigger reads one until eight clocks
// - Shift eight data bits out
// - Received bits readable as parallel byte
// - Mask bit gates serial interrupt
// - Flag sets per byte; write one clears
// - Request held while flag and mask set
module csi_serial #(
    parameter bit NEG_POL = 1'b0
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire csi_pkg::csi_wb_req_type wb_req_i,
    output      csi_pkg::csi_wb_rsp_type wb_rsp_o,
    input  wire logic [3:0]              pin_i,
    input  wire logic [3:0]              gp_o_i,
    input  wire logic [3:0]              gp_oe_i,
    input  wire logic                    low_speed_osc_i,
    input  wire logic                    timer_underflow_i,
    output      csi_pkg::csi_pins_type   pins_o,
    output      logic                    irq_o
);
    import csi_pkg::*;

    csi_state_type q;
    csi_state_type n;
    logic          hit;
    logic          wr;
    logic [15:0]   idx;
    logic          tick;
    logic          rise;
    logic          fall;
    logic          bit_in;
    logic          trg_wr;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = q;
        // Pins and oscillator are foreign: three stages, accept on agreement
        n.sync1 = {low_speed_osc_i, pin_i[2], pin_i[0]};
        n.sync2 = q.sync1;
        n.sync3 = q.sync2;
        for (int i = 0; i < 3; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                n.filt[i] = q.sync2[i];
            end
        end

        // Bus slave: one-cycle answer, unmapped reads zero
        hit    = wb_req_i.cyc & wb_req_i.stb & ~q.rsp.ack;
        wr     = hit & wb_req_i.we & wb_req_i.sel[0];
        idx    = wb_req_i.adr[17:2];
        trg_wr = 1'b0;
        n.rsp.ack = hit;
        n.rsp.dat = 32'h0;
        if (hit && !wb_req_i.we) begin
            unique case (idx)
                `CSI_IDX_PULL: n.rsp.dat[3:0] = q.pull;
                `CSI_IDX_CTL:  n.rsp.dat[3:0] = {1'b0, q.soe, q.phase, q.en};
                `CSI_IDX_FMT:  n.rsp.dat[3:0] = {q.msb, q.edge_sel, q.mode};
                `CSI_IDX_DLO:  n.rsp.dat[3:0] = q.sh[3:0];
                `CSI_IDX_DHI:  n.rsp.dat[3:0] = q.sh[7:4];
                `CSI_IDX_MASK: n.rsp.dat[3:0] = {3'h0, q.mask};
                `CSI_IDX_FLAG: n.rsp.dat[3:0] = {3'h0, q.flag};
                default:       n.rsp.dat = 32'h0;
            endcase
        end
        // Any data access restarts the bit counter while stopped
        if (hit && (idx == `CSI_IDX_DLO || idx == `CSI_IDX_DHI)
            && q.phase == CSI_IDLE) begin
            n.cnt = 3'h0;
        end
        if (wr) begin
            unique case (idx)
                `CSI_IDX_PULL: n.pull = wb_req_i.dat[3:0];
                `CSI_IDX_CTL: begin
                    n.en   = wb_req_i.dat[`CSI_CTL_EN];
                    n.soe  = wb_req_i.dat[`CSI_CTL_SOE];
                    trg_wr = wb_req_i.dat[`CSI_CTL_TRG];
                end
                `CSI_IDX_FMT: begin
                    n.mode     = csi_mode_type'(wb_req_i.dat[1:0]);
                    n.edge_sel = wb_req_i.dat[`CSI_FMT_EDGE];
                    n.msb      = wb_req_i.dat[`CSI_FMT_MSB];
                end
                `CSI_IDX_DLO: n.sh[3:0] = wb_req_i.dat[3:0];
                `CSI_IDX_DHI: n.sh[7:4] = wb_req_i.dat[3:0];
                `CSI_IDX_MASK: n.mask = wb_req_i.dat[`CSI_IRQ_BIT];
                `CSI_IDX_FLAG: begin
                    if (wb_req_i.dat[`CSI_IRQ_BIT]) begin
                        n.flag = 1'b0;
                    end
                end
                default: n.flag = q.flag;
            endcase
        end
        // A second trigger during a run is dropped, not restarted
        if (trg_wr && q.phase == CSI_IDLE) begin
            n.phase = CSI_RUN;
            n.cnt   = 3'h0;
        end

        // Clock source: internal level is always positive-polarity
        unique case (q.mode)
            CSI_OSC:   tick = n.filt[2] ^ q.filt[2];
            CSI_DIV2:  tick = n.filt[2] & ~q.filt[2];
            CSI_TIMER: tick = timer_underflow_i;
            CSI_SLAVE: tick = 1'b0;
        endcase
        if (q.mode == CSI_SLAVE) begin
            n.sclk = n.filt[1] ^ NEG_POL;
        end else if (q.phase == CSI_RUN) begin
            if (tick) begin
                n.sclk = ~q.sclk;
            end
        end else begin
            n.sclk = 1'b1;
        end
        rise = n.sclk & ~q.sclk & (q.phase == CSI_RUN);
        fall = ~n.sclk & q.sclk & (q.phase == CSI_RUN);

        // Sampling on the leading edge holds the bit until the shift
        if (fall && !q.edge_sel) begin
            n.rx_bit = q.filt[0];
        end
        bit_in = q.edge_sel ? q.filt[0] : q.rx_bit;
        if (rise) begin
            if (q.msb) begin
                n.sh = {q.sh[6:0], bit_in};
            end else begin
                n.sh = {bit_in, q.sh[7:1]};
            end
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == `CSI_LAST_BIT) begin
                n.phase = CSI_IDLE;
                n.flag  = 1'b1;
                n.cnt   = 3'h0;
            end
        end

        // Output bit follows the shift register, so it moves on the trailing edge
        n.serial_data_out = n.msb ? n.sh[7] : n.sh[0];
        n.irq  = n.flag & n.mask;

        // Pin multiplexer, registered so every pin comes from a flop
        n.pins.o  = gp_o_i;
        n.pins.oe = gp_oe_i;
        if (n.en) begin
            n.pins.oe[0] = 1'b0;
            if (n.soe) begin
                n.pins.o[1]  = n.serial_data_out;
                n.pins.oe[1] = 1'b1;
            end
            if (n.mode == CSI_SLAVE) begin
                n.pins.oe[2] = 1'b0;
                n.pins.o[3]  = (n.phase == CSI_RUN);
                n.pins.oe[3] = 1'b1;
            end else begin
                n.pins.o[2]  = n.sclk ^ NEG_POL;
                n.pins.oe[2] = 1'b1;
            end
        end
        // A driven pin never needs its pull-down
        n.pins.pd = n.pull & ~n.pins.oe;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q       <= '0;
            q.sclk  <= 1'b1;
            q.pull  <= `CSI_PULL_RST;
            q.mode  <= CSI_SLAVE;
            q.phase <= CSI_IDLE;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state flops
    assign wb_rsp_o = q.rsp;
    assign pins_o   = q.pins;
    assign irq_o    = q.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic rise_q;
    logic trg_q;

    // Edge and trigger history for the checks only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_q <= 1'b0;
            trg_q  <= 1'b0;
        end else begin
            rise_q <= rise;
            trg_q  <= trg_wr & (q.phase == CSI_IDLE);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_in_pin;
        q.en |-> !pins_o.oe[0];
    endproperty
    a_in_pin: assert property (p_in_pin)
        else $error("data-in pin driven while enabled");

    property p_ready;
        q.en && q.mode == CSI_SLAVE |-> pins_o.oe[3] && pins_o.o[3] == q.phase;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready pin wrong in slave mode");

    property p_out_pin;
        q.en && q.soe |-> pins_o.oe[1] && pins_o.o[1] == q.serial_data_out;
    endproperty
    a_out_pin: assert property (p_out_pin)
        else $error("data-out pin not driven");

    property p_clk_pd;
        q.en && q.mode != CSI_SLAVE |-> !pins_o.pd[2] && pins_o.oe[2];
    endproperty
    a_clk_pd: assert property (p_clk_pd)
        else $error("clock pin pull-down in master mode");

    property p_timer_half;
        q.phase == CSI_RUN && q.mode == CSI_TIMER && timer_underflow_i
            |=> q.sclk != $past(q.sclk);
    endproperty
    a_timer_half: assert property (p_timer_half)
        else $error("timer underflow did not toggle clock");

    property p_trigger;
        trg_q |-> q.phase == CSI_RUN ##1 q.phase == CSI_RUN;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger did not start a run");

    property p_eight;
        rise_q && $past(q.cnt) == `CSI_LAST_BIT |-> q.phase == CSI_IDLE && q.flag;
    endproperty
    a_eight: assert property (p_eight)
        else $error("eighth edge did not end the run");

    property p_stop;
        q.phase == CSI_RUN && rise && q.cnt != `CSI_LAST_BIT |=> q.phase == CSI_RUN;
    endproperty
    a_stop: assert property (p_stop)
        else $error("run ended before eight edges");

    property p_out_stable;
        q.phase == CSI_RUN && !rise && !hit |=> $stable(q.serial_data_out);
    endproperty
    a_out_stable: assert property (p_out_stable)
        else $error("output bit moved off its edge");

    property p_irq;
        q.flag && q.mask |-> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request dropped");

    c_run: cover property (trg_q ##[1:1000] $fell(q.phase));
    c_irq: cover property ($rose(irq_o));
    c_slave: cover property (q.mode == CSI_SLAVE && rise);
endmodule

// [tb/csi_peer.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Far-side partner: clock source in slave mode, data both ways
// ----------------------------------------
module csi_peer (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic       gen_i,
    input  wire logic       edge_i,
    input  wire logic       msb_i,
    input  wire logic [7:0] tx_i,
    input  wire logic       lclk_i,
    input  wire logic       serial_data_out_i,
    output logic            sclk_o,
    output logic            sdi_o,
    output logic [7:0]      rx_o,
    output logic            busy_o
);
    logic [7:0] tx_q;
    logic [3:0] nb_q;
    logic [3:0] nr_q;
    logic [4:0] half_q;
    logic [2:0] tick_q = 3'h0;
    logic       prev_q = 1'b1;
    logic       rise;
    logic       fall;
    // Wire position of the n-th bit
    function automatic logic [2:0] pos(input logic [3:0] n);
        return msb_i ? 3'(4'h7 - n) : n[2:0];
    endfunction
    assign rise = lclk_i & ~prev_q;
    assign fall = prev_q & ~lclk_i;
    initial begin
        sclk_o = 1'b1;
        sdi_o  = 1'b0;
        busy_o = 1'b0;
    end
    // Frame sequencing in the system clock domain
    always @(posedge clk_i) begin
        prev_q <= lclk_i;
        tick_q <= tick_q + 3'h1;
        if (start_i) begin
            busy_o <= 1'b1;
            tx_q   <= tx_i;
            half_q <= 5'h0;
            nr_q   <= 4'h0;
            nb_q   <= {3'h0, ~edge_i};
            if (!edge_i)
                sdi_o <= tx_i[pos(4'h0)];
        end else if (busy_o) begin
            // Idle-high clock, 16 levels of 8 cycles, under the rate limit
            if (gen_i && tick_q == 3'h7 && half_q != 5'h10) begin
                sclk_o <= ~sclk_o;
                half_q <= half_q + 5'h1;
            end
            // Next bit goes out on the edge away from the sampling one
            if ((edge_i ? fall : rise) && nb_q != 4'h8) begin
                sdi_o <= tx_q[pos(nb_q)];
                nb_q  <= nb_q + 4'h1;
            end
            // Device bits taken mid-bit
            if (fall && nr_q != 4'h8) begin
                rx_o[pos(nr_q)] <= serial_data_out_i;
                nr_q            <= nr_q + 4'h1;
            end
            // Eighth rising edge ends the frame; data line toggled
            if (rise && nr_q == 4'h8) begin
                busy_o <= 1'b0;
                sdi_o  <= ~sdi_o;
            end
        end
    end
endmodule

// [tb/csi_serial_tb.sv]
`timescale 1ns/100ps
`include "csi_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module csi_serial_tb;
    import csi_pkg::*;
    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    csi_wb_req_type req = '0;
    csi_wb_rsp_type rsp;
    csi_pins_type   pins;
    logic [3:0]     pin_i;
    logic [3:0]     gp_o = 4'h0;
    logic [3:0]     gp_oe = 4'h0;
    logic           osc = 1'b0;
    logic           tmr = 1'b0;
    logic           irq;
    logic           start = 1'b0;
    logic           gen = 1'b0;
    logic           edge_s = 1'b0;
    logic           msb = 1'b0;
    logic [7:0]     ptx = 8'h0;
    logic [7:0]     prx;
    logic           psclk;
    logic           psdi;
    logic           pbusy;
    int             miscompares = 0;
    int             total_checks = 0;
    logic [15:0]    idx [8] = '{`CSI_IDX_PULL, `CSI_IDX_CTL, `CSI_IDX_FMT, `CSI_IDX_DLO,
                                `CSI_IDX_DHI, `CSI_IDX_MASK, `CSI_IDX_FLAG, 16'hffff};
    logic [3:0]     rstv [8] = '{4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    // Clock, oscillator at an unrelated rate, timer pulse every 10 cycles
    always #4 clk_i = ~clk_i;
    always #76 osc = ~osc;
    always begin
        repeat (9) @(posedge clk_i);
        tmr <= 1'b1;
        @(posedge clk_i);
        tmr <= 1'b0;
    end
    // Wire level: a driver wins, else far side or pull
    always_comb begin
        for (int k = 0; k < 4; k++)
            pin_i[k] = pins.oe[k] ? pins.o[k] : ~pins.pd[k];
        if (!pins.oe[0])
            pin_i[0] = psdi;
        if (!pins.oe[2])
            pin_i[2] = psclk;
    end
    csi_serial i_csi_serial (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .pin_i(pin_i), .gp_o_i(gp_o), .gp_oe_i(gp_oe), .low_speed_osc_i(osc),
        .timer_underflow_i(tmr), .pins_o(pins), .irq_o(irq));
    csi_peer i_csi_peer (.clk_i(clk_i), .start_i(start), .gen_i(gen), .edge_i(edge_s),
        .msb_i(msb), .tx_i(ptx), .lclk_i(pin_i[2]), .serial_data_out_i(pin_i[1]), .sclk_o(psclk),
        .sdi_o(psdi), .rx_o(prx), .busy_o(pbusy));
    // Classic single bus cycle; waits for ack under a bound
    task automatic wb(input logic we, input logic [15:0] a, input logic [3:0] wd,
                      output logic [3:0] rd);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, we, {a, 2'b00}, 4'h1, {28'h0, wd}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 40);
        rd = rsp.dat[3:0];
        if (n >= 40)
            miscompares++;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        logic [3:0] x;
        wb(1'b1, a, d, x);
    endtask
    task automatic kick();
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, well past eight frames
    initial begin
        #400000;
        miscompares++;
        end_of_test();
    end
    // Main sequence
    initial begin
        logic [3:0] v;
        logic [3:0] fmt;
        logic [7:0] dtx;
        int         n;
        void'($urandom(58));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        gp_o  <= 4'($urandom);
        gp_oe <= 4'($urandom);
        repeat (2) @(posedge clk_i);
        `CHK({pins.o, pins.oe, pins.pd}, {gp_o, gp_oe, ~gp_oe})
        wr(16'hffff, 4'hf);
        foreach (idx[i]) begin
            wb(1'b0, idx[i], 4'h0, v);
            `CHK(v, rstv[i])
        end
        gp_oe <= 4'h0;
        wr(`CSI_IDX_PULL, 4'h0);
        `CHK(pins.pd, 4'h0)
        wr(`CSI_IDX_PULL, 4'hf);
        // Every clock source and both sampling edges
        for (int i = 0; i < 8; i++) begin
            fmt = {1'($urandom), i[2], i[1:0]};
            dtx = 8'($urandom);
            ptx <= 8'($urandom);
            msb <= fmt[3];
            edge_s <= fmt[2];
            gen <= (i[1:0] == 2'b00);
            wr(`CSI_IDX_FMT, fmt);
            wr(`CSI_IDX_MASK, {3'h0, i[0]});
            wr(`CSI_IDX_DLO, dtx[3:0]);
            wr(`CSI_IDX_DHI, dtx[7:4]);
            wr(`CSI_IDX_CTL, 4'h5);
            if (i[1:0] != 2'b00)
                kick();
            wr(`CSI_IDX_CTL, 4'h7);
            if (i[1:0] == 2'b00)
                kick();
            wr(`CSI_IDX_CTL, 4'h5);
            wb(1'b0, `CSI_IDX_CTL, 4'h0, v);
            `CHK(v, 4'h7)
            if (i[1:0] == 2'b00)
                `CHK({pins.oe[3:1], pins.o[3]}, 4'hb)
            else
                `CHK(pins.oe[3:1], {gp_oe[3], 2'h3})
            n = 0;
            do begin
                wb(1'b0, `CSI_IDX_CTL, 4'h0, v);
                n++;
            end while (v[1] !== 1'b0 && n < 300);
            `CHK(v, 4'h5)
            if (i[1:0] == 2'b00)
                `CHK(pins.o[3], 1'b0)
            wb(1'b0, `CSI_IDX_DLO, 4'h0, v);
            `CHK(v, ptx[3:0])
            wb(1'b0, `CSI_IDX_DHI, 4'h0, v);
            `CHK(v, ptx[7:4])
            `CHK(prx, dtx)
            wb(1'b0, `CSI_IDX_FLAG, 4'h0, v);
            `CHK(v, 4'h1)
            wr(`CSI_IDX_FLAG, 4'h0);
            `CHK(irq, i[0])
            wr(`CSI_IDX_FLAG, 4'h1);
            `CHK(irq, 1'b0)
            wb(1'b0, `CSI_IDX_FLAG, 4'h0, v);
            `CHK(v, 4'h0)
        end
        end_of_test();
    end
endmodule
